// ===== core/ref8k_cfg.svh
// register offsets, field positions, reset values and timing counts
// for the global 8 kHz reference and reference clock select block.
// assumes nothing beyond being included by its bare name.
`ifndef REF8K_CFG_SVH
`define REF8K_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CTRL2_IDX 6'h04
`define PINCTL_IDX 6'h0a
`define PINRD_IDX 6'h1c

// ************************************************************
// reset values
// ************************************************************
`define CTRL2_RST 16'h0000
`define PINCTL_RST 16'h0000

// ************************************************************
// field positions in global_control_two
// ************************************************************
`define SRC_LSB 10
`define OUT_SEL_BIT 9
`define IN_SEL_BIT 8
`define RATE_ADAPTER_REF_INPUT_LSB 1
`define CTRL2_MASK 16'h0f0e

// ************************************************************
// field positions of the pin status read register
// ************************************************************
`define PINRD_REF_BIT 8

// ************************************************************
// timing: reference rate and divider length
// ************************************************************
`define CLK_HZ 50000000
`define REF8K_HZ 8000
`define REF8K_DIV_CYCLES (`CLK_HZ / `REF8K_HZ)

`endif

// ===== core/ref8k_pkg.sv
// types for the global 8 kHz reference and reference clock select block.
// uses none of the constants of ref8k_cfg.svh; its encodings are literal numbers.
package ref8k_pkg;

  // ************************************************************
  // field encodings
  // ************************************************************
  typedef enum logic [1:0] {
    SRC_OFF = 2'b00,
    SRC_ADAPTER = 2'b01,
    SRC_PORT = 2'b10,
    SRC_UNDEF = 2'b11
  } src_t;

  typedef enum logic [1:0] {
    FN_INPUT = 2'b00,
    FN_ALT = 2'b01,
    FN_DRIVE0 = 2'b10,
    FN_DRIVE1 = 2'b11
  } pin_fn_t;

  typedef enum logic [2:0] {
    RATE_ADAPTER_REF_INPUT_44M736 = 3'b000,
    RATE_ADAPTER_REF_INPUT_34M368 = 3'b001,
    RATE_ADAPTER_REF_INPUT_51M84 = 3'b010,
    RATE_ADAPTER_REF_INPUT_19M44 = 3'b011,
    RATE_ADAPTER_REF_INPUT_77M76 = 3'b100
  } rate_adapter_ref_input_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pins_t;

endpackage : ref8k_pkg

// ===== core/global_ref8k_and_rate_adapter_ref_input_select.sv
// global 8 kHz reference source select, reference output routing,
// rate adapter reference clock field and general pin control.
// assumes a classic wishbone master on clk, pins that are asynchronous,
// and a rate adapter tick and port reference from logic on clk.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "ref8k_cfg.svh"

// Functional notes
// - source 00, no pin input: divider off
// - source 01: reference from rate adapter clock
// - source 10: port selected reference used
// - pin input select: pin 4 is reference
// - chosen reference feeds timer and ports
// - pin input off: pin 4 follows field
// - unselected pin input signals held low
// - output select: reference driven on pin 2
// - rate_adapter_ref_input field states rate adapter frequency
// - pin control: eight fields, reset zero
// - field codes: input, alt, drive 0/1
// - source field ignored under pin input
module global_ref8k_and_rate_adapter_ref_input_select #(
  parameter logic [15:0] REF8K_DIV = 16'(`REF8K_DIV_CYCLES)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reference sources and port status
  input wire logic rate_adapter_tick,
  input wire logic port_ref8k,
  input wire logic [1:0] port_status,
  // general pins
  input wire logic [7:0] pin_in,
  output ref8k_pkg::pins_t pins,
  // derived references and rate adapter setup
  output logic ref8k_global,
  output logic global_ref8k_in,
  output logic ref8k_pin_ref,
  output ref8k_pkg::rate_adapter_ref_input_t rate_adapter_rate_adapter_ref_input_sel
);
  import ref8k_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************

  // byte-lane merge of a 16-bit register with bus write data
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : lane_merge

  // {oe_n, out} for a pin in a given function; alt is the routed level
  function automatic logic [1:0] pin_drive(input pin_fn_t fn, input logic alt);
    logic [1:0] res;
    res = 2'b10;
    unique case (fn)
      FN_INPUT: res = 2'b10;
      FN_ALT: res = {1'b0, alt};
      FN_DRIVE0: res = 2'b00;
      FN_DRIVE1: res = 2'b01;
    endcase
    return res;
  endfunction : pin_drive

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;

  // two stages: pins are asynchronous to clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ************************************************************
  // wishbone register file
  // ************************************************************
  logic [15:0] ctrl2_q;
  logic [15:0] ctrl2_d;
  logic [15:0] pinctl_q;
  logic [15:0] pinctl_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic req;
  logic wr_en;
  logic hit_ctrl2;
  logic hit_pinctl;
  logic hit_pinrd;

  assign req = wb_cyc_i & wb_stb_i;
  assign hit_ctrl2 = (wb_adr_i[7:2] == `CTRL2_IDX);
  assign hit_pinctl = (wb_adr_i[7:2] == `PINCTL_IDX);
  assign hit_pinrd = (wb_adr_i[7:2] == `PINRD_IDX);
  // a write lands on the edge where ack is seen high
  assign wr_en = req & wb_we_i & ack_q;

  // next values: one wait state, unmapped reads return zero
  always_comb begin
    ctrl2_d = ctrl2_q;
    pinctl_d = pinctl_q;
    ack_d = req & ~ack_q;
    rdat_d = rdat_q;
    if (wr_en && hit_ctrl2) begin
      ctrl2_d = lane_merge(ctrl2_q, wb_dat_i, wb_sel_i) & `CTRL2_MASK;
    end
    if (wr_en && hit_pinctl) begin
      pinctl_d = lane_merge(pinctl_q, wb_dat_i, wb_sel_i);
    end
    if (req && !ack_q) begin
      rdat_d = 32'h0000_0000;
      if (hit_ctrl2) begin
        rdat_d[15:0] = ctrl2_q;
      end else if (hit_pinctl) begin
        rdat_d[15:0] = pinctl_q;
      end else if (hit_pinrd) begin
        rdat_d[7:0] = pin_sync_q;
        rdat_d[`PINRD_REF_BIT] = ref8k_global;
      end
    end
  end

  // field reset to zero on every pin function
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_q <= `CTRL2_RST;
      pinctl_q <= `PINCTL_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ctrl2_q <= ctrl2_d;
      pinctl_q <= pinctl_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ************************************************************
  // control fields
  // ************************************************************
  src_t src;
  logic in_sel;
  logic out_sel;
  assign src = src_t'(ctrl2_q[`SRC_LSB +: 2]);
  assign in_sel = ctrl2_q[`IN_SEL_BIT];
  assign out_sel = ctrl2_q[`OUT_SEL_BIT];

  // ************************************************************
  // 8 kHz divider on rate adapter ticks
  // ************************************************************
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic div_run;
  logic div_sq;

  // the divider only runs when its output is the chosen source,
  // so it stays parked (and quiet) in every other setting
  assign div_run = !in_sel && (src == SRC_ADAPTER);
  assign div_sq = (div_q < (REF8K_DIV >> 1));

  always_comb begin
    div_d = div_q;
    if (!div_run) begin
      div_d = 16'h0000;
    end else if (rate_adapter_tick) begin
      div_d = (div_q >= REF8K_DIV - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_d;
    end
  end

  // ************************************************************
  // reference select and pin functions
  // ************************************************************
  logic ref_d;
  logic pin_in_ref_d;
  pins_t pins_d;
  pins_t pins_q;
  logic [1:0] drv;
  logic ref_q;
  logic pin_in_ref_q;
  logic pin_ref_q;
  rate_adapter_ref_input_t rate_adapter_ref_input_q;

  // source priority: pin input select overrides the source field
  always_comb begin
    pin_in_ref_d = in_sel ? pin_sync_q[3] : 1'b0;
    ref_d = 1'b0;
    if (in_sel) begin
      ref_d = pin_sync_q[3];
    end else begin
      unique case (src)
        SRC_OFF: ref_d = 1'b0;
        SRC_ADAPTER: ref_d = div_sq;
        SRC_PORT: ref_d = port_ref8k;
        SRC_UNDEF: ref_d = 1'b0;
      endcase
    end
  end

  // code 01 routes port status on pins 1 and 2, reserved elsewhere
  always_comb begin
    pins_d = '{out: 8'h00, oe_n: 8'hff};
    drv = 2'b10;
    for (int i = 0; i < 8; i++) begin
      drv = 2'b10;
      if ((i < 2) || (pinctl_q[2*i +: 2] != FN_ALT)) begin
        drv = pin_drive(pin_fn_t'(pinctl_q[2*i +: 2]), port_status[i % 2]);
      end
      pins_d.oe_n[i] = drv[1];
      pins_d.out[i] = drv[0];
    end
    if (in_sel) begin
      pins_d.oe_n[3] = 1'b1;
      pins_d.out[3] = 1'b0;
    end
    if (out_sel) begin
      pins_d.oe_n[1] = 1'b0;
      pins_d.out[1] = ref_d;
    end
  end

  // every output is registered; one cycle from the select to the pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      pin_in_ref_q <= 1'b0;
      pin_ref_q <= 1'b0;
      pins_q <= '{out: 8'h00, oe_n: 8'hff};
      rate_adapter_ref_input_q <= RATE_ADAPTER_REF_INPUT_44M736;
    end else begin
      ref_q <= ref_d;
      pin_in_ref_q <= pin_in_ref_d;
      pin_ref_q <= pin_in_ref_d;
      pins_q <= pins_d;
      rate_adapter_ref_input_q <= rate_adapter_ref_input_t'(ctrl2_q[`RATE_ADAPTER_REF_INPUT_LSB +: 3]);
    end
  end

  assign ref8k_global = ref_q;
  assign global_ref8k_in = pin_in_ref_q;
  assign ref8k_pin_ref = pin_ref_q;
  assign pins = pins_q;
  assign rate_adapter_rate_adapter_ref_input_sel = rate_adapter_ref_input_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_pinctl_write;
    req && wb_we_i && hit_pinctl && (wb_sel_i[1:0] == 2'b11) && ack_q;
  endsequence

  sequence s_bus_start;
    req && !ack_q && !wb_we_i;
  endsequence

  chk_src_off_quiet: assert property (
    (!in_sel && src == SRC_OFF) [*2] |-> !ref8k_global && div_q == 16'h0000)
    else $error("reference active with source disabled");
  chk_src_adapter_path: assert property (
    (!in_sel && src == SRC_ADAPTER) |=> ref8k_global == $past(div_sq))
    else $error("reference does not follow divider");
  chk_src_port_path: assert property (
    (!in_sel && src == SRC_PORT) |=> ref8k_global == $past(port_ref8k))
    else $error("reference does not follow port reference");
  chk_pin4_source: assert property (
    in_sel |-> ##1 (ref8k_global == $past(pin_sync_q[3])) && pins.oe_n[3])
    else $error("pin 4 not used as reference input");
  chk_pin4_mode: assert property (
    (!in_sel && pinctl_q[7:6] == FN_DRIVE1) |=> !pins.oe_n[3] && pins.out[3])
    else $error("pin 4 ignores its function field");
  chk_input_low: assert property (
    !in_sel |=> !global_ref8k_in && !ref8k_pin_ref)
    else $error("unselected pin reference not low");

  chk_pin2_output: assert property (
    out_sel |=> !pins.oe_n[1] && pins.out[1] == ref8k_global)
    else $error("pin 2 does not carry the reference");

  chk_rate_adapter_ref_input_field: assert property (
    ##1 rate_adapter_rate_adapter_ref_input_sel == rate_adapter_ref_input_t'($past(ctrl2_q[3:1])))
    else $error("rate_adapter_ref_input select not taken from field");

  chk_pinctl_write: assert property (
    s_pinctl_write |=> pinctl_q == $past(wb_dat_i[15:0]))
    else $error("pin control write lost");

  chk_bus_answer: assert property (
    s_bus_start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

  chk_alt_reserved: assert property (
    (!in_sel && pinctl_q[7:6] == FN_ALT) |=> pins.oe_n[3])
    else $error("reserved code drives pin 4");

endmodule : global_ref8k_and_rate_adapter_ref_input_select

// ===== sim/tb_global_ref8k_and_rate_adapter_ref_input_select.sv
// self-checking bench for the global 8 kHz reference select block.
// assumes the block acks every wishbone request one cycle after taking it.
`timescale 1ns/1ps
module tb_global_ref8k_and_rate_adapter_ref_input_select;
  import ref8k_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk = 1'b0;
  logic nrst;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic ack, tick, pref;
  logic [1:0] pst;
  logic [7:0] pin_in;
  pins_t pins;
  logic ref_g, ref_in, ref_pin;
  rate_adapter_ref_input_t rate_adapter_ref_input;
  logic [31:0] expq[$];
  integer seed = 32'hd8a9;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer i, n;
  logic [15:0] d;

  // short divider keeps the adapter-derived reference quick to observe
  global_ref8k_and_rate_adapter_ref_input_select #(.REF8K_DIV(16'h0008)) uut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rate_adapter_tick(tick), .port_ref8k(pref),
    .port_status(pst), .pin_in(pin_in), .pins(pins), .ref8k_global(ref_g),
    .global_ref8k_in(ref_in), .ref8k_pin_ref(ref_pin),
    .rate_adapter_rate_adapter_ref_input_sel(rate_adapter_ref_input)
  );

  always #10 clk = ~clk;

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task end_of_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // one classic cycle; ack is read at the rising edge, before that edge's updates land,
  // so the request is released right after the very edge at which the design saw ack
  task bus(input logic w, input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, v};
    sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack timeout", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  // a write is followed by enough cycles for the registered outputs to land
  task wr(input logic [7:0] a, input logic [15:0] v);
    bus(1'b1, a, v);
    repeat (2) @(negedge clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back({16'h0000, e});
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // read data is compared against the oldest note at the ack edge
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
      if (expq.size() == 0) chk("unexpected read", 32'h0, 32'h1);
      else chk("read data", expq.pop_front(), rdat);
    end
  end

  // watchdog well beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    tick = 1'b0;
    pref = 1'b0;
    pst = 2'b00;
    pin_in = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h10, 16'h0000);
    rd(8'h28, 16'h0000);
    rd(8'h3c, 16'h0000);
    // random source and select bits, undefined source code kept out
    d = 16'($random(seed)) & 16'h0700;
    wr(8'h10, d);
    rd(8'h10, d);
    for (i = 0; i < 5; i++) begin
      wr(8'h10, {12'h000, 3'(i), 1'b0});
      rd(8'h10, {12'h000, 3'(i), 1'b0});
      chk("rate_adapter_ref_input sel", i, rate_adapter_ref_input);
    end
    // pin1 status, pin2 low, pin3 high, pin4 input, pin5 high
    pst <= 2'($random(seed));
    wr(8'h28, 16'h0339);
    rd(8'h28, 16'h0339);
    chk("pin oe_n", 8'he8, pins.oe_n);
    chk("pin out", {27'h0, 4'b1010, pst[0]}, pins.out[4:0] & ~pins.oe_n[4:0]);
    // pin2 routes status, pins 3 and 4 treat the reserved code as input
    wr(8'h28, 16'h0054);
    chk("alt codes", {27'h0, pst[1], 4'hd}, {27'h0, pins.out[1], pins.oe_n[3:0]});
    wr(8'h28, 16'h03f9);
    chk("pin4 driven", 2'b10, {pins.out[3], pins.oe_n[3]});
    // pin input select overrides pin4 field and the source field
    @(posedge clk);
    pref <= 1'b0;
    wr(8'h10, 16'h0900);
    chk("pin4 released", 1'b1, pins.oe_n[3]);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      pin_in <= 8'($random(seed));
      repeat (4) @(negedge clk);
      chk("ref from pin", pin_in[3], ref_g);
      chk("ref in", pin_in[3], ref_in);
      chk("pin ref", pin_in[3], ref_pin);
    end
    // port reference, pin input held at 1 but not selected
    @(posedge clk);
    pin_in <= 8'hff;
    wr(8'h10, 16'h0800);
    rd(8'h70, 16'h00ff);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      pref <= 1'($random(seed));
      repeat (2) @(negedge clk);
      chk("ref from port", pref, ref_g);
      chk("ref in idle", 2'b00, {ref_in, ref_pin});
    end
    // reference routed out on pin 2 over its drive-low field
    @(posedge clk);
    pref <= 1'b1;
    wr(8'h10, 16'h0a00);
    chk("pin2 ref out", 2'b10, {pins.out[1], pins.oe_n[1]});
    wr(8'h10, 16'h0800);
    chk("pin2 field", 2'b00, {pins.out[1], pins.oe_n[1]});
    // divider off
    wr(8'h10, 16'h0000);
    repeat (4) @(negedge clk);
    chk("ref off", 1'b0, ref_g);
    // adapter ticks every cycle: half of sixteen cycles high
    wr(8'h10, 16'h0400);
    @(posedge clk);
    tick <= 1'b1;
    repeat (8) @(negedge clk);
    n = 0;
    for (i = 0; i < 16; i++) begin
      @(negedge clk);
      if (ref_g === 1'b1) n++;
    end
    chk("adapter ref duty", 8, n);
    @(posedge clk);
    tick <= 1'b0;
    repeat (4) @(posedge clk);
    chk("queue empty", 0, expq.size());
    end_of_test;
  end
endmodule : tb_global_ref8k_and_rate_adapter_ref_input_select
